// ---- rchh_counter.sv ----
// Purpose: Down counter that times each busy phase
// Assumes: Load and run come from the controller on the same clock
// Notes:   Done is registered
`default_nettype none
module rchh_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadVal,
  output var  logic             done
);
  logic [WIDTH-1:0] count_r;

  // ==========================================================
  // Counter
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_r <= '0;
      done    <= 1'b0;
    end else if (clkEn) begin
      if (load) begin
        count_r <= loadVal;
        done    <= 1'b0;
      end else if (count_r != '0) begin
        count_r <= count_r - 1'b1;
        done    <= (count_r == {{(WIDTH-1){1'b0}}, 1'b1});
      end else begin
        done    <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rchh_ctrl.sv ----
// Purpose: Busy, read strobe, read-data qualify and error handshake
// Assumes: User strobes come from logic on the same clock
// Notes:   Channel work is timed by one counter standing in for the link
`default_nettype none
`include "rchh_params.svh"

// Summary of operation
// [R01] Busy is low for the first clock after reset, then high during offset cancellation.
// [R02] Busy falls only when offset cancellation has finished on all receivers.
// [R03] In analog control mode busy is high for each whole read or write.
// [R04] In other modes busy is high while the settings image is written.
// [R05] User logic pulses read for one clock to start a read.
// [R06] Reads are honoured only in analog control and transmit divide modes.
// [R07] The read qualifier is high while read-back data are valid.
// [R08] The read qualifier exists only when a read-back port is enabled; the port is always present here, tied low when READBACK_EN is 0.
// [R09] An unsupported request drops busy and holds error high two clocks.
// [R10] User logic pulses write for one clock to start a write.
// [R11] Continuous write sends the whole image on one pulse, else one word per pulse.
// [R12] User logic issues no strobe while busy is high.
module rchh_ctrl
  import rchh_pkg::*;
#(
  parameter int  CW          = 16,
  parameter int  DW          = 8,
  parameter int  OC_CYC      = `RCHH_OC_CYC_DEF,
  parameter int  XFER_CYC    = `RCHH_XFER_CYC_DEF,
  parameter int  WORD_CYC    = `RCHH_WORD_CYC_DEF,
  parameter int  IMG_WORDS   = `RCHH_IMG_WORDS_DEF,
  parameter bit  READBACK_EN = 1'b1,
  parameter bit  CONT_WRITE  = 1'b1
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          clkEn,
  input  wire rchh_mode_e    reconfigMode,
  input  wire logic          readStrobe,
  input  wire logic          writeStrobe,
  input  wire logic [DW-1:0] writeData,
  input  wire logic [DW-1:0] channelReadData,
  output var  logic          busy,
  output var  logic          readResultQualifier,
  output var  logic [DW-1:0] readData,
  output var  logic [DW-1:0] channelWriteData,
  output var  logic          error
);
  localparam int ERR_CYC = `RCHH_ERR_CYC;
  localparam int IMG_CYC = CONT_WRITE ? IMG_WORDS * WORD_CYC : WORD_CYC;

  rchh_state_e   state_r;
  rchh_state_e   state_nxt;
  logic          load;
  logic [CW-1:0] loadVal;
  logic          done;
  logic [1:0]    errCnt_r;

  // ==========================================================
  // Decoding
  function automatic logic readAllowed(input rchh_mode_e m);
    return (m == RCHH_MODE_ANALOG) || (m == RCHH_MODE_TXDIV); // [R06]
  endfunction

  // Offset cancellation and every channel phase count as busy; power-up and error do not
  function automatic logic isBusyState(input rchh_state_e s);
    case (s)
      RCHH_ST_OFFSET,
      RCHH_ST_READ,
      RCHH_ST_WRITE,
      RCHH_ST_IMAGE: return 1'b1;
      default:       return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Phase timer
  rchh_counter #(.WIDTH(CW)) timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .load    (load),
    .loadVal (loadVal),
    .done    (done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    load      = 1'b0;
    loadVal   = '0;
    case (state_r)
      RCHH_ST_PWRUP: begin
        state_nxt = RCHH_ST_OFFSET; // [R01]
        load      = 1'b1;
        loadVal   = CW'(OC_CYC);
      end
      RCHH_ST_OFFSET: begin
        if (done) begin
          state_nxt = RCHH_ST_IDLE; // [R02]
        end
      end
      RCHH_ST_IDLE: begin
        // Strobes during busy never reach here, so none are queued
        if (readStrobe) begin
          if (readAllowed(reconfigMode)) begin
            state_nxt = RCHH_ST_READ;
            load      = 1'b1;
            loadVal   = CW'(XFER_CYC);
          end else begin
            state_nxt = RCHH_ST_ERROR; // [R09]
          end
        end else if (writeStrobe) begin
          if (reconfigMode == RCHH_MODE_ANALOG) begin
            state_nxt = RCHH_ST_WRITE; // [R03]
            load      = 1'b1;
            loadVal   = CW'(XFER_CYC);
          end else if (reconfigMode == RCHH_MODE_IMAGE) begin
            state_nxt = RCHH_ST_IMAGE; // [R04]
            load      = 1'b1;
            loadVal   = CW'(IMG_CYC); // [R11]
          end else begin
            state_nxt = RCHH_ST_ERROR; // [R09]
          end
        end
      end
      RCHH_ST_READ,
      RCHH_ST_WRITE,
      RCHH_ST_IMAGE: begin
        if (done) begin
          state_nxt = RCHH_ST_IDLE;
        end
      end
      RCHH_ST_ERROR: begin
        if (errCnt_r == 2'(ERR_CYC - 1)) begin
          state_nxt = RCHH_ST_IDLE;
        end
      end
      default: begin
        state_nxt = RCHH_ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= RCHH_ST_PWRUP;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Error hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errCnt_r <= 2'h0;
    end else if (clkEn) begin
      if (state_r == RCHH_ST_ERROR) begin
        errCnt_r <= errCnt_r + 2'h1;
      end else begin
        errCnt_r <= 2'h0;
      end
    end
  end

  // ==========================================================
  // Busy and error, both registered from the next state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy  <= 1'b0;
      error <= 1'b0;
    end else if (clkEn) begin
      // Taken from the next state so busy moves with the state,
      // with no extra cycle of lag behind the strobe
      busy  <= isBusyState(state_nxt); // [R01] [R03] [R04]
      error <= (state_nxt == RCHH_ST_ERROR); // [R09]
    end
  end

  // ==========================================================
  // Read-back qualifier
  // Held until the next request, accepted or refused, so slow user logic can
  // still take the word after busy has fallen.
  // Tied low when no read-back port is built.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readResultQualifier <= 1'b0;
    end else if (clkEn) begin
      if (state_r == RCHH_ST_READ && done) begin
        readResultQualifier <= READBACK_EN; // [R07] [R08]
      end else if (state_nxt != RCHH_ST_IDLE && state_nxt != state_r) begin
        readResultQualifier <= 1'b0; // [R07]
      end
    end
  end

  // ==========================================================
  // Read-back data
  // Moves only at read end, never under a high qualifier
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readData <= '0;
    end else if (clkEn && state_r == RCHH_ST_READ && done) begin
      readData <= channelReadData; // [R07]
    end
  end

  // ==========================================================
  // Write word
  // Captured on any write strobe in idle; a refused write starts
  // no transfer, so the channel never acts on that word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channelWriteData <= '0;
    end else if (clkEn && state_r == RCHH_ST_IDLE && writeStrobe) begin
      channelWriteData <= writeData; // [R10]
    end
  end
endmodule
`default_nettype wire

// ---- rchh_ctrl_asserts.sv ----
// Purpose: Port assertions for rchh_ctrl
// Assumes: Bench counts: offset 8, transfer 3, image 2 words of 4
// Notes:   Busy lengths checked exactly; clkEn high while busy
`default_nettype none
module rchh_ctrl_asserts
  import rchh_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       clkEn,
  input wire rchh_mode_e reconfigMode,
  input wire logic       readStrobe,
  input wire logic       writeStrobe,
  input wire logic       busy,
  input wire logic       readResultQualifier,
  input wire logic       error
);
  timeunit 1ns / 1ns;
  wire logic rd = clkEn && !busy && !error && readStrobe;
  wire logic wr = clkEn && !busy && !error && writeStrobe && !readStrobe;
  wire logic an = reconfigMode == RCHH_MODE_ANALOG;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_PWRUP: assert property ($fell(sys_rst) |-> !busy ##1 busy)
    else $error("busy start");
  AST_OC:
    assert property ($fell(sys_rst) |-> ##1 busy[*8] ##1 busy ##1 !busy)
    else $error("offset end");
  AST_RDA:
    assert property (rd && an |=> busy && !readResultQualifier ##4
      $fell(busy) && readResultQualifier) else $error("read qualify");
  AST_RDX: assert property (rd && reconfigMode[1] |=> error && !busy)
    else $error("read refuse");
  AST_WRX: assert property (wr && reconfigMode[0] |=> error && !busy)
    else $error("write refuse");
  AST_ERR:
    assert property ($rose(error) |-> (!busy throughout error[*2]) ##1 !error)
    else $error("error length");
  AST_IMG:
    assert property (wr && reconfigMode == RCHH_MODE_IMAGE |=>
      busy[*8] ##1 busy ##1 !busy)
    else $error("image busy");
  AST_WRA: assert property (wr && an |=> busy[*4] ##1 !busy)
    else $error("write busy");
endmodule
bind rchh_ctrl rchh_ctrl_asserts u_chk (.*);
`default_nettype wire

// ---- rchh_ctrl_tb.sv ----
// Purpose: Self-checking bench for rchh_ctrl
// Assumes: Short offset and image counts
// Notes:   clkEn high except in tFreeze; strobes come from the user model
`default_nettype none
module rchh_ctrl_tb
  import rchh_pkg::*;
;
  timeunit 1ns / 1ns;
  logic       clock = 1'b0, sysRst = 1'b1, clkEn = 1'b1, rdS, wrS, busy;
  logic       qual, error;
  logic [7:0] wrD, chD = 8'h00, rdD, chW;
  rchh_mode_e mode = RCHH_MODE_ANALOG;
  int         miscompares = 0, checkCount = 0, cycles = 0, n;
  rchh_ctrl #(.OC_CYC(8), .XFER_CYC(3), .IMG_WORDS(2)) dut (.clock(clock),
    .sys_rst(sysRst), .clkEn(clkEn), .reconfigMode(mode), .readStrobe(rdS),
    .writeStrobe(wrS), .writeData(wrD), .channelReadData(chD), .busy(busy),
    .readResultQualifier(qual), .readData(rdD), .channelWriteData(chW),
    .error(error));
  rchh_user_model u_user (.clock(clock), .busy(busy), .error(error),
    .readStrobe(rdS), .writeStrobe(wrS), .writeData(wrD));
  initial forever #5 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: mismatch", $time);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (++cycles == 1000) miscompares++;
    if (cycles == 1000) summarize();
  end
  // Counts falling edges with busy high, from the current one on
  task automatic waitIdle();
    n = 0;
    while (busy === 1'b1 && n < 99) begin
      n++;
      @(negedge clock);
    end
  endtask
  // Release at a rising edge; busy low one cycle, then offset + 1
  task automatic tRelease();
    sysRst <= 1'b0;
    @(negedge clock) check(busy, 1'b0);
    @(negedge clock) check(busy, 1'b1);
    waitIdle();
    check(n, 9);
  endtask
  task automatic tXfer(rchh_mode_e m, logic r, logic [7:0] d, int len);
    @(posedge clock);
    mode <= m;
    chD  <= d;
    u_user.issue(r, !r, d, 0);
    @(negedge clock) check(busy, 1'b1);
    check(qual, 1'b0);
    waitIdle();
    check(n, len);
    if (r && m == RCHH_MODE_ANALOG)
      check(qual && rdD === d, 1'b1);
    if (!r)
      check(chW, d);
  endtask
  task automatic tBad(rchh_mode_e m, logic r);
    @(posedge clock);
    mode <= m;
    u_user.issue(r, !r, 8'h00, 0);
    repeat (2) begin
      @(negedge clock);
      check(error && !busy, 1'b1);
    end
    @(negedge clock) check(error, 1'b0);
  endtask
  // A strobe seen while clkEn is low must start nothing
  task automatic tFreeze();
    @(posedge clock);
    mode  <= RCHH_MODE_ANALOG;
    clkEn <= 1'b0;
    u_user.issue(1'b1, 1'b0, 8'h00, 0);
    repeat (2) begin
      @(negedge clock);
      check(busy || error, 1'b0);
    end
    @(posedge clock);
    clkEn <= 1'b1;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    tRelease();
    tFreeze();
    tXfer(RCHH_MODE_ANALOG, 1'b1, 8'ha5, 4);
    tXfer(RCHH_MODE_TXDIV, 1'b1, 8'h3c, 4);
    tBad(RCHH_MODE_IMAGE, 1'b1);
    tBad(RCHH_MODE_OTHER, 1'b1);
    tBad(RCHH_MODE_TXDIV, 1'b0);
    tBad(RCHH_MODE_OTHER, 1'b0);
    tXfer(RCHH_MODE_IMAGE, 1'b0, 8'h5a, 9);
    tXfer(RCHH_MODE_ANALOG, 1'b0, 8'hc3, 4);
    @(posedge clock);
    sysRst <= 1'b1;
    repeat (2) @(posedge clock);
    tRelease();
    summarize();
  end
endmodule
`default_nettype wire

// ---- rchh_params.svh ----
// Purpose: Constants for the reconfiguration handshake block
// Assumes: 100 MHz clock
// Notes:   Included by the controller module only
`ifndef RCHH_PARAMS_SVH
`define RCHH_PARAMS_SVH
// ==========================================================
// Timing
`define RCHH_CLK_PERIOD_NS   10
`define RCHH_PWRUP_LOW_CYC   1
`define RCHH_ERR_CYC         2
`define RCHH_OC_CYC_DEF      64
`define RCHH_XFER_CYC_DEF    8
`define RCHH_WORD_CYC_DEF    4
`define RCHH_IMG_WORDS_DEF   16
`endif

// ---- rchh_pkg.sv ----
// Purpose: Types for the reconfiguration handshake block
// Assumes: Nothing
// Notes:   State and mode enumerations
`default_nettype none
package rchh_pkg;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    RCHH_MODE_ANALOG,
    RCHH_MODE_TXDIV,
    RCHH_MODE_IMAGE,
    RCHH_MODE_OTHER
  } rchh_mode_e;

  typedef enum logic [2:0] {
    RCHH_ST_PWRUP,
    RCHH_ST_OFFSET,
    RCHH_ST_IDLE,
    RCHH_ST_READ,
    RCHH_ST_WRITE,
    RCHH_ST_IMAGE,
    RCHH_ST_ERROR
  } rchh_state_e;
endpackage
`default_nettype wire

// ---- rchh_user_model.sv ----
// Purpose: User logic that issues strobes
// Assumes: Shares the controller clock
// Notes:   Gap cycles model a slow user
`default_nettype none
module rchh_user_model (
  input  wire logic       clock,
  input  wire logic       busy,
  input  wire logic       error,
  output var  logic       readStrobe,
  output var  logic       writeStrobe,
  output var  logic [7:0] writeData
);
  timeunit 1ns / 1ns;
  initial {readStrobe, writeStrobe, writeData} = '0;
  // Looks at busy on falling edges, where it has settled
  task automatic issue(input logic r, w, input logic [7:0] d, input int g);
    @(negedge clock);
    while (busy !== 1'b0 || error !== 1'b0) @(negedge clock);
    repeat (g) @(negedge clock);
    @(posedge clock);
    readStrobe  <= r;
    writeStrobe <= w;
    writeData   <= d;
    @(posedge clock);
    readStrobe  <= 1'b0;
    writeStrobe <= 1'b0;
  endtask
endmodule
`default_nettype wire
